// file: ldm_display.sv
// Serial text display core: 9600 baud receiver and echo transmitter,
// eight-slot scrolling text buffer, colour pick and LED chain driver.
// Assumes all inputs are synchronous to clk_in and the glyph ROM
// answers one clock after its read strobe.
`timescale 1ns/1ps
module ldm_display
    import ldm_pkg::*;
#(
    parameter int unsigned BAUD_DIV = BAUD_DIV_DEF,
    parameter int unsigned LATCH_CYC = LATCH_CYC_DEF,
    parameter int unsigned REFRESH_DIV = REFRESH_DIV_DEF
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic uart_rx_in,
    input wire logic [1:0] chain_len_in,
    input wire logic echo_en_in,
    input wire logic [1:0] dim_sel_in,
    input wire logic refresh_ext_in,
    input wire logic colour_fixed_in,
    output logic led_data_out,
    output logic refresh_strobe_out,
    output logic uart_tx_out,
    output logic rx_valid_out
);
    // Refuse divisors the counters cannot serve
    if (BAUD_DIV < 16 || LATCH_CYC < 1 || REFRESH_DIV < 2) begin : g_bad
        $error("ldm_display: timing parameter out of range");
    end

    ldm_glyph_if gif ();
    ldm_char_rom u_rom (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .gif(gif)
    );

    logic rx_busy_reg;
    logic [31:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_valid_reg, rx_done;
    logic [15:0] lfsr_reg;
    logic [7:0] char_reg [MAX_CHARS];
    logic [3:0] col_reg [MAX_CHARS];
    logic [3:0] fixed_reg;
    logic tx_busy_reg;
    logic [31:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [8:0] tx_shift_reg;
    logic tx_line_reg;
    logic [31:0] ref_cnt_reg;
    logic pend_reg, ext_req, int_req;
    ldm_led_e st_reg;
    logic [2:0] ch_reg;
    logic [5:0] pix_reg;
    logic [4:0] bit_reg;
    logic [31:0] cnt_reg;
    logic [23:0] px_reg;
    logic [7:0] code_reg;
    logic rd_reg, led_reg, strobe_reg;
    logic [2:0] first_slot;
    logic [3:0] col_idx;
    logic [23:0] rgb;
    logic [31:0] thi;

    // Receiver: a stop bit sampled high at mid-bit completes a byte
    assign rx_done = rx_busy_reg && rx_cnt_reg == 32'h0000_0000
        && rx_bit_reg == 4'h9 && uart_rx_in;

    // Receiver framing: start, eight data bits LSB first, one stop
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_busy_reg <= 1'b0;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_shift_reg <= '0;
        end else if (!rx_busy_reg) begin
            if (!uart_rx_in) begin
                rx_busy_reg <= 1'b1;
                rx_cnt_reg <= BAUD_DIV / 2 - 1; // centre of start bit
                rx_bit_reg <= '0;
            end
        end else if (rx_cnt_reg != 32'h0000_0000) begin
            rx_cnt_reg <= rx_cnt_reg - 1;
        end else if (rx_bit_reg == 4'h0) begin
            // A start bit gone high by mid-bit was a glitch
            if (uart_rx_in) begin
                rx_busy_reg <= 1'b0;
            end else begin
                rx_bit_reg <= 4'h1;
                rx_cnt_reg <= BAUD_DIV - 1;
            end
        end else if (rx_bit_reg <= 4'h8) begin
            rx_shift_reg <= {uart_rx_in, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            rx_cnt_reg <= BAUD_DIV - 1;
        end else begin
            rx_busy_reg <= 1'b0; // Bad stop bit drops the byte quietly
        end
    end

    // One-cycle receive flag
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= rx_done;
        end
    end

    // Free-running Galois LFSR; its phase at receipt picks a colour
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lfsr_reg <= LFSR_SEED;
        end else if (lfsr_reg[0]) begin
            lfsr_reg <= (lfsr_reg >> 1) ^ LFSR_TAPS;
        end else begin
            lfsr_reg <= lfsr_reg >> 1;
        end
    end

    // Text buffer: slot 7 is rightmost, every byte scrolls in
    for (genvar i = 0; i < MAX_CHARS; i++) begin : g_slot
        logic [7:0] char_in;
        logic [3:0] col_in;
        assign char_in = (i == MAX_CHARS - 1) ? rx_shift_reg
            : char_reg[(i + 1) % MAX_CHARS];
        assign col_in = (i == MAX_CHARS - 1) ? lfsr_reg[3:0]
            : col_reg[(i + 1) % MAX_CHARS];
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                char_reg[i] <= SPACE_CHAR;
                col_reg[i] <= '0;
            end else if (rx_done) begin
                char_reg[i] <= char_in;
                col_reg[i] <= col_in;
            end
        end
    end

    // Fixed colour index from high bytes
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fixed_reg <= FIXED_COLOUR_RST;
        end else if (rx_done && rx_shift_reg[7]) begin
            fixed_reg <= rx_shift_reg[3:0];
        end
    end

    // Echo transmitter; a byte landing while busy is not echoed,
    // which is the price of having no flow control
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_busy_reg <= 1'b0;
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
            tx_shift_reg <= '1;
            tx_line_reg <= 1'b1;
        end else if (!tx_busy_reg) begin
            if (rx_done && echo_en_in) begin
                tx_busy_reg <= 1'b1;
                tx_shift_reg <= {1'b1, rx_shift_reg};
                tx_line_reg <= 1'b0;
                tx_cnt_reg <= BAUD_DIV - 1;
                tx_bit_reg <= '0;
            end
        end else if (tx_cnt_reg != 32'h0000_0000) begin
            tx_cnt_reg <= tx_cnt_reg - 1;
        end else if (tx_bit_reg == 4'h9) begin
            tx_busy_reg <= 1'b0;
        end else begin
            tx_line_reg <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_cnt_reg <= BAUD_DIV - 1;
        end
    end

    // Refresh triggers: self timer or end-of-line characters
    assign int_req = !refresh_ext_in
        && ref_cnt_reg == REFRESH_DIV - 1;
    assign ext_req = refresh_ext_in && rx_done
        && (rx_shift_reg == CARRIAGE_RETURN_CHAR
        || rx_shift_reg == LINE_FEED_CHAR);

    // Refresh timer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_cnt_reg <= '0;
        end else if (ref_cnt_reg == REFRESH_DIV - 1) begin
            ref_cnt_reg <= '0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 1;
        end
    end

    // Pending request; a new request wins over the clear at frame start
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_reg <= 1'b0;
        end else if (int_req || ext_req) begin
            pend_reg <= 1'b1;
        end else if (st_reg == ST_IDLE) begin
            pend_reg <= 1'b0;
        end
    end

    // Dimming: each step shifts every channel two places down
    function automatic logic [23:0] dim_rgb(input logic [23:0] c,
                                            input logic [1:0] s);
        logic [2:0] sh;
        sh = {s, 1'b0};
        dim_rgb = {c[23:16] >> sh, c[15:8] >> sh, c[7:0] >> sh};
    endfunction

    // Colour for the character being sent
    assign first_slot = {~chain_len_in, 1'b0};
    assign col_idx = colour_fixed_in ? fixed_reg : col_reg[ch_reg];
    assign rgb = dim_rgb(PALETTE[col_idx], dim_sel_in);
    assign thi = px_reg[bit_reg] ? T1H_CYC : T0H_CYC;
    assign gif.code = code_reg;
    assign gif.rd = rd_reg;

    // Frame sequencer: per slot fetch glyph, then 35 pixels of 24 bits
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= ST_IDLE;
            ch_reg <= '0;
            pix_reg <= '0;
            bit_reg <= '0;
            cnt_reg <= '0;
            px_reg <= '0;
            code_reg <= SPACE_CHAR;
            rd_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            rd_reg <= 1'b0;
            strobe_reg <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (pend_reg) begin
                        st_reg <= ST_FETCH;
                        ch_reg <= first_slot;
                        code_reg <= char_reg[first_slot];
                        rd_reg <= 1'b1;
                        strobe_reg <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    st_reg <= ST_LOAD;
                    pix_reg <= '0;
                end
                ST_LOAD: begin
                    // Lit pixels carry GRB colour, dark pixels zero
                    if (gif.glyph[PIX_PER_CHAR - 1 - pix_reg]) begin
                        px_reg <= {rgb[15:8], rgb[23:16], rgb[7:0]};
                    end else begin
                        px_reg <= '0;
                    end
                    bit_reg <= 5'(COLOUR_BITS - 1);
                    cnt_reg <= '0;
                    st_reg <= ST_SEND;
                end
                ST_SEND: begin
                    if (cnt_reg != TBIT_CYC - 1) begin
                        cnt_reg <= cnt_reg + 1;
                    end else begin
                        cnt_reg <= '0;
                        if (bit_reg != 5'h00) begin
                            bit_reg <= bit_reg - 5'h01;
                        end else if (pix_reg != 6'(PIX_PER_CHAR - 1)) begin
                            pix_reg <= pix_reg + 6'h01;
                            st_reg <= ST_LOAD;
                        end else if (ch_reg != 3'h7) begin
                            ch_reg <= ch_reg + 3'h1;
                            code_reg <= char_reg[ch_reg + 3'h1];
                            rd_reg <= 1'b1;
                            st_reg <= ST_FETCH;
                        end else begin
                            st_reg <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (cnt_reg != LATCH_CYC - 1) begin
                        cnt_reg <= cnt_reg + 1;
                    end else begin
                        cnt_reg <= '0;
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // Line is high for the first part of each bit slot only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            led_reg <= 1'b0;
        end else begin
            led_reg <= st_reg == ST_SEND && cnt_reg < thi;
        end
    end

    assign led_data_out = led_reg;
    assign refresh_strobe_out = strobe_reg;
    assign uart_tx_out = tx_line_reg;
    assign rx_valid_out = rx_valid_reg;

    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    chk_rx_valid_pulse: assert property (
        rx_valid_out |=> !rx_valid_out)
        else $error("receive valid held longer than one cycle");
    chk_rx_stop_high: assert property (
        rx_valid_out |-> $past(uart_rx_in))
        else $error("byte accepted without a high stop bit");
    chk_shift_left: assert property (
        rx_done |=> char_reg[7] == $past(rx_shift_reg)
            && char_reg[6] == $past(char_reg[7]))
        else $error("text did not scroll on receipt");
    chk_fixed_store: assert property (
        rx_done && rx_shift_reg[7] |=> fixed_reg == $past(rx_shift_reg[3:0]))
        else $error("fixed colour not stored from high byte");
    chk_echo_start: assert property (
        rx_done && echo_en_in && !tx_busy_reg |=> !uart_tx_out ##1
            !uart_tx_out)
        else $error("echo start bit missing");
    chk_ext_refresh: assert property (
        ext_req && st_reg == ST_IDLE |-> ##[2:3] refresh_strobe_out)
        else $error("end-of-line did not start a refresh");
    chk_strobe_frame: assert property (
        refresh_strobe_out |-> st_reg == ST_FETCH
            && ch_reg == $past(first_slot))
        else $error("strobe not aligned with frame start");
    chk_gap_low: assert property (
        st_reg == ST_GAP && $past(st_reg) == ST_GAP |-> !led_data_out)
        else $error("data line high during latch gap");
    chk_dim_none: assert property (
        dim_sel_in == 2'h0 |-> rgb == PALETTE[col_idx])
        else $error("colour altered with dimming off");
endmodule

// file: ldm_pkg.sv
// Shared constants for the serial text display: timing, characters,
// frame layout and the LED sequencer states.
// Assumes one 200 MHz system clock shared by every module.
package ldm_pkg;
    // System clock and serial line
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned BAUD_RATE = 9600;
    localparam int unsigned BAUD_DIV_DEF = CLK_HZ / BAUD_RATE;
    localparam int unsigned UART_BITS = 8;
    // LED one-wire timing; high times are least times, so round up
    localparam int unsigned T0H_NS = 400;
    localparam int unsigned T1H_NS = 800;
    localparam int unsigned TBIT_NS = 1250;
    localparam int unsigned LATCH_US = 50;
    localparam int unsigned T0H_CYC = (T0H_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned T1H_CYC = (T1H_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TBIT_CYC = (TBIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LATCH_CYC_DEF = LATCH_US * CLK_MHZ;
    // Self-timed refresh rate
    localparam int unsigned REFRESH_HZ = 75;
    localparam int unsigned REFRESH_DIV_DEF = CLK_HZ / REFRESH_HZ;
    // Display geometry
    localparam int unsigned MAX_CHARS = 8;
    localparam int unsigned PIX_PER_CHAR = 35;
    localparam int unsigned COLOUR_BITS = 24;
    // Characters
    localparam logic [7:0] CARRIAGE_RETURN_CHAR = 8'h0d;
    localparam logic [7:0] LINE_FEED_CHAR = 8'h0a;
    localparam logic [7:0] SPACE_CHAR = 8'h20;
    localparam logic [7:0] PRINT_HI_CHAR = 8'h7e;
    localparam logic [34:0] RECT_GLYPH =
        {5'h1f, 5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h1f};
    // Pseudo-random colour source; seed value is arbitrary
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    localparam logic [3:0] FIXED_COLOUR_RST = 4'h0;
    // Colour table as RGB; the sixteen values are free picks
    localparam logic [23:0] PALETTE [16] = '{
        24'hff_0000, 24'h00_ff00, 24'h00_00ff, 24'hff_ff00,
        24'hff_00ff, 24'h00_ffff, 24'hff_ffff, 24'hff_8000,
        24'h80_00ff, 24'h00_ff80, 24'hff_0080, 24'h80_ff00,
        24'h00_80ff, 24'hff_8080, 24'h80_ff80, 24'h80_80ff
    };
    // LED sequencer, Gray-coded along idle-fetch-load-send-gap
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_LOAD = 3'h3,
        ST_SEND = 3'h2,
        ST_GAP = 3'h6
    } ldm_led_e;
endpackage

// file: ldm_glyph_if.sv
// Glyph lookup channel between the display core and the character ROM.
// Assumes the ROM answers one clock after a read strobe.
`timescale 1ns/1ps
interface ldm_glyph_if;
    logic [7:0] code;
    logic rd;
    logic [34:0] glyph;
    modport core (output code, output rd, input glyph);
    modport rom (input code, input rd, output glyph);
endinterface

// file: ldm_char_rom.sv
// Character ROM: 5x7 glyphs, row 0 at the top, bit 4 the left column.
// Assumes the core holds code steady while rd is high; data registered.
`timescale 1ns/1ps
module ldm_char_rom
    import ldm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    ldm_glyph_if.rom gif
);
    logic [34:0] glyph_reg;
    logic [7:0] fold;

    // Fold lower case onto upper case so one glyph serves both
    always_comb begin
        fold = gif.code;
        if (gif.code >= 8'h61 && gif.code <= 8'h7a) begin
            fold = gif.code - 8'h20;
        end
    end

    // Table lookup; unlisted printables show a centre dot
    function automatic logic [34:0] lookup(input logic [7:0] c);
        logic [34:0] g;
        g = {5'h00, 5'h00, 5'h00, 5'h04, 5'h00, 5'h00, 5'h00};
        if (c < SPACE_CHAR || c > PRINT_HI_CHAR) begin
            g = RECT_GLYPH;
        end else begin
            case (c)
                8'h20: g = '0;
                8'h30: g = {5'h0e,5'h11,5'h13,5'h15,5'h19,5'h11,5'h0e};
                8'h31: g = {5'h04,5'h0c,5'h04,5'h04,5'h04,5'h04,5'h0e};
                8'h32: g = {5'h0e,5'h11,5'h01,5'h02,5'h04,5'h08,5'h1f};
                8'h33: g = {5'h1f,5'h02,5'h04,5'h02,5'h01,5'h11,5'h0e};
                8'h34: g = {5'h02,5'h06,5'h0a,5'h12,5'h1f,5'h02,5'h02};
                8'h35: g = {5'h1f,5'h10,5'h1e,5'h01,5'h01,5'h11,5'h0e};
                8'h36: g = {5'h06,5'h08,5'h10,5'h1e,5'h11,5'h11,5'h0e};
                8'h37: g = {5'h1f,5'h01,5'h02,5'h04,5'h08,5'h08,5'h08};
                8'h38: g = {5'h0e,5'h11,5'h11,5'h0e,5'h11,5'h11,5'h0e};
                8'h39: g = {5'h0e,5'h11,5'h11,5'h0f,5'h01,5'h02,5'h0c};
                8'h41: g = {5'h0e,5'h11,5'h11,5'h1f,5'h11,5'h11,5'h11};
                8'h42: g = {5'h1e,5'h11,5'h11,5'h1e,5'h11,5'h11,5'h1e};
                8'h43: g = {5'h0e,5'h11,5'h10,5'h10,5'h10,5'h11,5'h0e};
                8'h44: g = {5'h1c,5'h12,5'h11,5'h11,5'h11,5'h12,5'h1c};
                8'h45: g = {5'h1f,5'h10,5'h10,5'h1e,5'h10,5'h10,5'h1f};
                8'h46: g = {5'h1f,5'h10,5'h10,5'h1e,5'h10,5'h10,5'h10};
                8'h47: g = {5'h0e,5'h11,5'h10,5'h17,5'h11,5'h11,5'h0f};
                8'h48: g = {5'h11,5'h11,5'h11,5'h1f,5'h11,5'h11,5'h11};
                8'h49: g = {5'h0e,5'h04,5'h04,5'h04,5'h04,5'h04,5'h0e};
                8'h4a: g = {5'h07,5'h02,5'h02,5'h02,5'h02,5'h12,5'h0c};
                8'h4b: g = {5'h11,5'h12,5'h14,5'h18,5'h14,5'h12,5'h11};
                8'h4c: g = {5'h10,5'h10,5'h10,5'h10,5'h10,5'h10,5'h1f};
                8'h4d: g = {5'h11,5'h1b,5'h15,5'h15,5'h11,5'h11,5'h11};
                8'h4e: g = {5'h11,5'h11,5'h19,5'h15,5'h13,5'h11,5'h11};
                8'h4f: g = {5'h0e,5'h11,5'h11,5'h11,5'h11,5'h11,5'h0e};
                8'h50: g = {5'h1e,5'h11,5'h11,5'h1e,5'h10,5'h10,5'h10};
                8'h51: g = {5'h0e,5'h11,5'h11,5'h11,5'h15,5'h12,5'h0d};
                8'h52: g = {5'h1e,5'h11,5'h11,5'h1e,5'h14,5'h12,5'h11};
                8'h53: g = {5'h0f,5'h10,5'h10,5'h0e,5'h01,5'h01,5'h1e};
                8'h54: g = {5'h1f,5'h04,5'h04,5'h04,5'h04,5'h04,5'h04};
                8'h55: g = {5'h11,5'h11,5'h11,5'h11,5'h11,5'h11,5'h0e};
                8'h56: g = {5'h11,5'h11,5'h11,5'h11,5'h11,5'h0a,5'h04};
                8'h57: g = {5'h11,5'h11,5'h11,5'h15,5'h15,5'h15,5'h0a};
                8'h58: g = {5'h11,5'h11,5'h0a,5'h04,5'h0a,5'h11,5'h11};
                8'h59: g = {5'h11,5'h11,5'h11,5'h0a,5'h04,5'h04,5'h04};
                8'h5a: g = {5'h1f,5'h01,5'h02,5'h04,5'h08,5'h10,5'h1f};
                default: g = g;
            endcase
        end
        return g;
    endfunction

    // Registered read port; holds its data between reads
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            glyph_reg <= '0;
        end else if (gif.rd) begin
            glyph_reg <= lookup(fold);
        end
    end
    assign gif.glyph = glyph_reg;

    chk_rect_glyph: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        gif.rd && (gif.code < SPACE_CHAR || gif.code > PRINT_HI_CHAR)
        |=> gif.glyph == RECT_GLYPH)
        else $error("non-printable code did not give the outline glyph");
endmodule

// file: ldm_term_model.sv
// Serial terminal model: sends 8N1 frames and decodes the echo line.
// Assumes the bit period is DIV cycles of the display's clock.
`timescale 1ns/1ps
module ldm_term_model #(
    parameter int unsigned DIV = 16
) (
    input wire logic clk_in,
    input wire logic tx_line_in,
    output logic rx_line_out
);
    logic [7:0] echo_byte = 8'h00;
    int echo_cnt = 0;
    initial rx_line_out = 1'b1; // Idle high, pulled up between frames
    // Start bit, data LSB first, stop bit of chosen level
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_in);
            rx_line_out = f[i];
            repeat (DIV - 1) @(negedge clk_in);
        end
        @(negedge clk_in);
        rx_line_out = 1'b1;
        repeat (DIV) @(negedge clk_in);
    endtask
    // Sample each echoed bit mid-cell; count only good stop bits
    always begin
        @(negedge tx_line_in);
        repeat (DIV / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk_in);
            echo_byte[i] = tx_line_in;
        end
        repeat (DIV) @(posedge clk_in);
        if (tx_line_in === 1'b1) echo_cnt++;
    end
endmodule

// file: ldm_display_tb.sv
// Self-checking bench for the serial text display.
// Assumes short baud and refresh divisors; frames are cut by reset.
`timescale 1ns/1ps
module ldm_display_tb;
    import ldm_pkg::*;
    localparam int unsigned DIV = 16;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic echo_en = 1'b1;
    logic ref_ext = 1'b1;
    logic fixed = 1'b0;
    logic [1:0] chain = 2'h0;
    logic [1:0] dim = 2'h0;
    logic rx, led, strobe, tx, rxv;
    int fail_count = 0, total_checks = 0, rxv_n = 0, strb_n = 0, n;
    always #2.5 clk_in = ~clk_in;
    ldm_display #(.BAUD_DIV(DIV), .LATCH_CYC(10), .REFRESH_DIV(2000)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .uart_rx_in(rx),
        .chain_len_in(chain), .echo_en_in(echo_en), .dim_sel_in(dim),
        .refresh_ext_in(ref_ext), .colour_fixed_in(fixed),
        .led_data_out(led), .refresh_strobe_out(strobe),
        .uart_tx_out(tx), .rx_valid_out(rxv));
    ldm_term_model #(.DIV(DIV)) term_u (.clk_in(clk_in),
        .tx_line_in(tx), .rx_line_out(rx));
    // Count one-cycle pulses; a stuck pulse shows as extra counts
    always @(posedge clk_in) begin
        if (rxv === 1'b1) rxv_n++;
        if (strobe === 1'b1) strb_n++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Waits while led matches lvl, bounded, leaving the cycle count in n
    task automatic wait_led(input logic lvl, input int lim);
        n = 0;
        while (led === lvl && n < lim) begin
            @(negedge clk_in);
            n++;
        end
    endtask
    // Sends an end-of-line byte and leaves in n the width of the first
    // high pulse of the frame that it starts
    task automatic first_bit(input logic [7:0] eol);
        fork
            term_u.send(eol, 1'b1);
            begin
                n = 0;
                while (strobe !== 1'b1 && n < 20 * DIV) begin
                    @(negedge clk_in);
                    n++;
                end
                wait_led(1'b0, 50);
                wait_led(1'b1, 500);
            end
        join
    endtask
    // Watchdog: the tests need well under 10,000 cycles
    initial begin
        #100us;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (2) @(negedge clk_in);
        rstn_in = 1'b1;
        chk({4'h0, led, strobe, tx, rxv}, 8'h02);
        term_u.send(8'h41, 1'b1);
        repeat (12 * DIV) @(negedge clk_in);
        chk(term_u.echo_byte, 8'h41);
        chk_cnt(rxv_n, 1);
        echo_en = 1'b0;
        term_u.send(8'h42, 1'b0);
        chk_cnt(rxv_n, 1);
        // A high byte sets the fixed colour and shows as an outline
        term_u.send(8'h85, 1'b1);
        repeat (12 * DIV) @(negedge clk_in);
        chk_cnt(term_u.echo_cnt, 1);
        chk_cnt(rxv_n, 2);
        chk_cnt(strb_n, 0);
        // Strongest dimming clears the first colour bit of any palette
        dim = 2'h3;
        first_bit(CARRIAGE_RETURN_CHAR);
        chk_cnt(n, T0H_CYC);
        chk_cnt(strb_n, 1);
        // Reset cuts the frame; the fixed colour then lights the outline
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rstn_in = 1'b1;
        fixed = 1'b1;
        dim = 2'h0;
        term_u.send(8'h85, 1'b1);
        first_bit(LINE_FEED_CHAR);
        chk_cnt(n, PALETTE[5][15] ? T1H_CYC : T0H_CYC);
        chk_cnt(strb_n, 2);
        // Another reset aborts the frame and selects self-timed refresh
        ref_ext = 1'b0;
        chain = 2'h3;
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        chk({7'h00, led}, 8'h00);
        rstn_in = 1'b1;
        n = 0;
        while (strobe !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        chk_cnt(n >= 1995 && n <= 2005, 1);
        conclude();
    end
endmodule
